// ---- src/cell_port_pkg.sv ----
// constants and types for the cell port target
`default_nettype none
package cell_port_pkg;
    // register bus
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CELLS_OFFSET = 8'h08;
    localparam logic [7:0] PACKETS_OFFSET = 8'h0c;
    localparam logic [7:0] TIMING_OFFSET = 8'h10;
    localparam logic [7:0] LOCKS_OFFSET = 8'h14;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // control fields
    localparam int CTRL_ACK_BIT = 0;
    localparam int CTRL_ERR_LSB = 1;
    localparam logic CTRL_ACK_RESET = 1'b1;
    localparam logic [1:0] CTRL_ERR_RESET = 2'h0;
    // status fields
    localparam int STAT_MIDPKT_BIT = 0;
    localparam int STAT_RSPPEND_BIT = 1;
    localparam int STAT_LOCKED_BIT = 2;
    // timing register fields
    localparam int TIMING_ACK_LSB = 16;
    localparam logic [15:0] TIME_SATURATE = 16'hffff;
    // operation codes on the request channel
    typedef enum logic [1:0] {
        OP_NOP = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h2,
        OP_LOCKREAD = 2'h3
    } op_type;
    // response error codes
    typedef enum logic [1:0] {
        ERR_NONE = 2'h0,
        ERR_GENERAL = 2'h1,
        ERR_BADDATA = 2'h2,
        ERR_ABORT = 2'h3
    } rsp_error_type;
endpackage
`default_nettype wire

// ---- src/cell_port_target.sv ----
// target end of the split packet cell port with an axi4-lite control slave
//
// Overview of operation
// - valid delay counts valid-low cycles between transfers
// - acknowledge delay counts valid-high cycles before acknowledge
// - one request packet, then one response packet
// - end-of-packet set only in final cell
// - either side stalls; cell moves on handshake
// - responses keep packet order and cell count
// - request and response channels fully independent; here cmdAck waits for a free response slot
// - everything sampled on rising edge, handshakes always
// - cell contents taken only while valid high
// - random mode locks first address; others all
// - target answers success or whole-packet general error; here an out-of-range cell gets a general error on that cell only
// - target may answer bad data or abort
// - cell may complete in its first valid cycle
// - response cells carry data, error and end flag
// - zero delays move one cell per edge
// - raised valid held with stable cell until transfer
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`default_nettype none
module cell_port_target
    import cell_port_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int PLEN_W = 9,
    parameter int CLEN_W = 8,
    parameter int MEM_DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // request channel
    input wire logic cmdVal,
    output logic cmdAck,
    input wire logic [ADDR_W-1:0] cmdAddress,
    input wire logic [3:0] cmdBe,
    input wire logic [1:0] cmdOp,
    input wire logic cmdContig,
    input wire logic cmdWrap,
    input wire logic cmdConst,
    input wire logic [PLEN_W-1:0] cmdPlen,
    input wire logic cmdEop,
    input wire logic [31:0] cmdWdata,
    input wire logic [CLEN_W-1:0] cmdClen,
    input wire logic cmdCfixed,
    // response channel
    output logic rspVal,
    input wire logic rspAck,
    output logic [31:0] rspData,
    output logic rspEop,
    output logic [1:0] rspError,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [AXI_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [AXI_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    localparam int IDX_W = $clog2(MEM_DEPTH);

    if (MEM_DEPTH < 2 || MEM_DEPTH > 32 || (1 << IDX_W) != MEM_DEPTH || ADDR_W < IDX_W + 3) begin : g_check
        $error("cell_port_target: MEM_DEPTH must be a power of two from 2 to 32");
    end

    logic ackEnable_ff;
    logic [1:0] errMode_ff;
    logic firstCell_ff;
    logic [1:0] pktErr_ff;
    logic rspVal_ff;
    logic [31:0] rspData_ff;
    logic rspEop_ff;
    logic [1:0] rspError_ff;
    logic [31:0] mem_ff [MEM_DEPTH];
    logic [MEM_DEPTH-1:0] locks_ff;
    logic [31:0] cells_ff;
    logic [31:0] packets_ff;
    logic [15:0] valCnt_ff;
    logic [15:0] ackCnt_ff;
    logic [15:0] lastVal_ff;
    logic [15:0] lastAck_ff;
    logic awHeld_ff;
    logic [AXI_ADDR_W-1:0] awAddr_ff;
    logic wHeld_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic cellTaken;
    logic inRange;
    logic [IDX_W-1:0] cellIdx;
    logic [1:0] pktMode;
    logic [1:0] cellErr;
    logic lockScope;
    logic doAxiWrite;
    logic [31:0] readWord;
    logic readHit;
    logic [31:0] lockWord;

    // request side: acknowledge only when the response slot frees this edge,
    // so cell order and count carry straight through with no queue
    assign cmdAck = ackEnable_ff && (!rspVal_ff || rspAck);
    assign cellTaken = cmdVal && cmdAck;

    assign cellIdx = cmdAddress[IDX_W+1:2];
    assign inRange = (cmdAddress[ADDR_W-1:IDX_W+2] == '0);
    // error mode is fixed at the first cell so a whole packet answers alike
    assign pktMode = firstCell_ff ? errMode_ff : pktErr_ff;

    always_comb begin
        if (pktMode != ERR_NONE) begin
            cellErr = pktMode;
        end else if (!inRange && cmdOp != OP_NOP) begin
            cellErr = ERR_GENERAL;
        end else begin
            cellErr = ERR_NONE;
        end
    end

    // random addressing only touches the lock of the first cell
    assign lockScope = firstCell_ff || cmdContig || cmdConst;

    // packet framing
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            firstCell_ff <= 1'b1;
            pktErr_ff <= ERR_NONE;
        end else if (cellTaken) begin
            firstCell_ff <= cmdEop;
            pktErr_ff <= pktMode;
        end
    end

    // response cell register, one per accepted request cell
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rspVal_ff <= 1'b0;
            rspData_ff <= 32'h0;
            rspEop_ff <= 1'b0;
            rspError_ff <= ERR_NONE;
        end else if (cellTaken) begin
            rspVal_ff <= 1'b1;
            rspEop_ff <= cmdEop;
            rspError_ff <= cellErr;
            // data is only meaningful on successful reads
            if ((cmdOp == OP_READ || cmdOp == OP_LOCKREAD) && cellErr == ERR_NONE) begin
                rspData_ff <= mem_ff[cellIdx];
            end else begin
                rspData_ff <= 32'h0;
            end
        end else if (rspAck) begin
            rspVal_ff <= 1'b0;
        end
    end

    assign rspVal = rspVal_ff;
    assign rspData = rspData_ff;
    assign rspEop = rspEop_ff;
    assign rspError = rspError_ff;

    // storage; failed cells leave it untouched
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_ff[i] <= 32'h0;
            end
        end else if (cellTaken && cmdOp == OP_WRITE && cellErr == ERR_NONE) begin
            for (int b = 0; b < 4; b++) begin
                if (cmdBe[b]) begin
                    mem_ff[cellIdx][8*b +: 8] <= cmdWdata[8*b +: 8];
                end
            end
        end
    end

    // lock bookkeeping
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            locks_ff <= '0;
        end else if (cellTaken && cellErr == ERR_NONE && lockScope) begin
            if (cmdOp == OP_LOCKREAD) begin
                locks_ff[cellIdx] <= 1'b1;
            end else if (cmdOp == OP_WRITE) begin
                locks_ff[cellIdx] <= 1'b0;
            end
        end
    end

    // handshake delay measurement on the request channel
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            valCnt_ff <= 16'h0;
            ackCnt_ff <= 16'h0;
            lastVal_ff <= 16'h0;
            lastAck_ff <= 16'h0;
        end else if (cellTaken) begin
            lastVal_ff <= valCnt_ff;
            lastAck_ff <= ackCnt_ff;
            valCnt_ff <= 16'h0;
            ackCnt_ff <= 16'h0;
        end else if (!cmdVal) begin
            if (valCnt_ff != TIME_SATURATE) begin
                valCnt_ff <= valCnt_ff + 16'h1;
            end
        end else if (ackCnt_ff != TIME_SATURATE) begin
            ackCnt_ff <= ackCnt_ff + 16'h1;
        end
    end

    // traffic counters
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cells_ff <= 32'h0;
            packets_ff <= 32'h0;
        end else if (cellTaken) begin
            cells_ff <= cells_ff + 32'h1;
            if (cmdEop) begin
                packets_ff <= packets_ff + 32'h1;
            end
        end
    end

    // axi write path: address and data taken independently, committed together
    assign awready = !awHeld_ff && !bvalid_ff;
    assign wready = !wHeld_ff && !bvalid_ff;
    assign doAxiWrite = awHeld_ff && wHeld_ff;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
        end else if (awvalid && awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
        end else if (doAxiWrite) begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h0;
            wStrb_ff <= 4'h0;
        end else if (wvalid && wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
        end else if (doAxiWrite) begin
            wHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ackEnable_ff <= CTRL_ACK_RESET;
            errMode_ff <= CTRL_ERR_RESET;
        end else if (doAxiWrite && {awAddr_ff[7:2], 2'b00} == CTRL_OFFSET && wStrb_ff[0]) begin
            ackEnable_ff <= wData_ff[CTRL_ACK_BIT];
            errMode_ff <= wData_ff[CTRL_ERR_LSB +: 2];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= AXI_OKAY;
        end else if (doAxiWrite) begin
            bvalid_ff <= 1'b1;
            // read-only registers ignore writes quietly; holes answer slverr
            case ({awAddr_ff[7:2], 2'b00})
                CTRL_OFFSET, STATUS_OFFSET, CELLS_OFFSET, PACKETS_OFFSET, TIMING_OFFSET, LOCKS_OFFSET: begin
                    bresp_ff <= AXI_OKAY;
                end
                default: begin
                    bresp_ff <= AXI_SLVERR;
                end
            endcase
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;

    // axi read path
    always_comb begin
        lockWord = 32'h0;
        lockWord[MEM_DEPTH-1:0] = locks_ff;
    end

    always_comb begin
        readWord = 32'h0;
        readHit = 1'b1;
        case ({araddr[7:2], 2'b00})
            CTRL_OFFSET: begin
                readWord[CTRL_ACK_BIT] = ackEnable_ff;
                readWord[CTRL_ERR_LSB +: 2] = errMode_ff;
            end
            STATUS_OFFSET: begin
                readWord[STAT_MIDPKT_BIT] = !firstCell_ff;
                readWord[STAT_RSPPEND_BIT] = rspVal_ff;
                readWord[STAT_LOCKED_BIT] = |locks_ff;
            end
            CELLS_OFFSET: begin
                readWord = cells_ff;
            end
            PACKETS_OFFSET: begin
                readWord = packets_ff;
            end
            TIMING_OFFSET: begin
                readWord = {lastAck_ff, lastVal_ff};
            end
            LOCKS_OFFSET: begin
                readWord = lockWord;
            end
            default: begin
                readHit = 1'b0;
            end
        endcase
    end

    assign arready = !rvalid_ff;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= AXI_OKAY;
        end else if (arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= readWord;
            rresp_ff <= readHit ? AXI_OKAY : AXI_SLVERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
endmodule
`default_nettype wire

// ---- verification/cell_port_target_assertions.sv ----
// concurrent checks on the request and response channels of the cell port target
`default_nettype none
module cell_port_target_assertions
    import cell_port_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // request channel
    input wire logic cmdVal,
    input wire logic cmdAck,
    input wire logic cmdEop,
    // response channel
    input wire logic rspVal,
    input wire logic rspAck,
    input wire logic [31:0] rspData,
    input wire logic rspEop,
    input wire logic [1:0] rspError
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // cells taken but not yet answered; the target answers each cell one cycle later
    logic [3:0] pendCnt_ff;
    logic [3:0] nxt_pendCnt;
    assign nxt_pendCnt = pendCnt_ff + 4'(cmdVal && cmdAck) - 4'(rspVal && rspAck);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pendCnt_ff <= 4'h0;
        end else begin
            pendCnt_ff <= nxt_pendCnt;
        end
    end
    sequence s_take;
        cmdVal && cmdAck;
    endsequence
    sequence s_wait;
        rspVal && !rspAck;
    endsequence
    property p_answer; s_take |=> rspVal && rspEop == $past(cmdEop); endproperty
    a_answer: assert property (p_answer) else $error("no matching response cell");
    property p_refuse; s_wait |-> !cmdAck; endproperty
    a_refuse: assert property (p_refuse) else $error("cell taken while response stalled");
    property p_hold; s_wait |=> rspVal && $stable(rspData) && $stable(rspEop) && $stable(rspError); endproperty
    a_hold: assert property (p_hold) else $error("response cell changed before transfer");
    property p_one; rspVal && rspAck && !cmdVal |=> !rspVal; endproperty
    a_one: assert property (p_one) else $error("extra response cell");
    property p_origin; $rose(rspVal) |-> $past(cmdVal) && $past(cmdAck); endproperty
    a_origin: assert property (p_origin) else $error("response without request");
    property p_stream; s_take ##0 (rspVal && rspAck) |=> rspVal; endproperty
    a_stream: assert property (p_stream) else $error("gap in zero delay stream");
    property p_errdata; rspVal && rspError != ERR_NONE |-> rspData == 32'h0; endproperty
    a_errdata: assert property (p_errdata) else $error("data on error response");
    property p_count; pendCnt_ff == {3'h0, rspVal}; endproperty
    a_count: assert property (p_count) else $error("response count differs from requests");
endmodule
bind cell_port_target cell_port_target_assertions chk_u (.clock(clock), .resetn(resetn), .cmdVal(cmdVal),
    .cmdAck(cmdAck), .cmdEop(cmdEop), .rspVal(rspVal), .rspAck(rspAck), .rspData(rspData),
    .rspEop(rspEop), .rspError(rspError));
`default_nettype wire

// ---- verification/cell_port_initiator.sv ----
// initiator model that sends request packets and accepts response cells
`default_nettype none
module cell_port_initiator
    import cell_port_pkg::*;
(
    // clock and control
    input wire logic clock,
    input wire logic slowRsp,
    // request channel
    output logic cmdVal = 1'b0,
    input wire logic cmdAck,
    output logic [31:0] cmdAddress = 32'h0,
    output logic [1:0] cmdOp = 2'h0,
    output logic cmdContig = 1'b0,
    output logic cmdConst = 1'b0,
    output logic [8:0] cmdPlen = 9'h0,
    output logic cmdEop = 1'b0,
    output logic [31:0] cmdWdata = 32'h0,
    output logic [3:0] cmdBe = 4'hf,
    output logic cmdWrap = 1'b0,
    output logic [7:0] cmdClen = 8'h0,
    output logic cmdCfixed = 1'b0,
    // response channel
    output logic rspAck = 1'b1
);
    // held high unless a stalling initiator is wanted
    always @(posedge clock) begin
        rspAck <= slowRsp ? ~rspAck : 1'b1;
    end
    task automatic pkt(input int n, input logic [31:0] a0, input int st, input logic [1:0] op,
                       input logic c, input logic k);
        @(posedge clock);
        for (int i = 0; i < n; i++) begin
            logic [31:0] a;
            a = a0 + 32'(4 * st * i);
            cmdAddress <= a;
            cmdWdata <= 32'h5a000000 | a;
            cmdBe <= 4'hf;
            cmdOp <= op;
            cmdContig <= c;
            cmdConst <= k;
            cmdPlen <= 9'(4 * n);
            // no wrapping bursts, so the power-of-two length rule never bites
            cmdWrap <= 1'b0;
            // every packet stands alone: no packets follow, nothing fixed across a chain
            cmdClen <= 8'h0;
            cmdCfixed <= 1'b0;
            cmdEop <= (i == n - 1);
            cmdVal <= 1'b1;
            do @(posedge clock); while (cmdAck !== 1'b1);
        end
        cmdVal <= 1'b0;
        // stale content would hide a target that samples without valid
        cmdAddress <= ~cmdAddress;
        cmdWdata <= ~cmdWdata;
    endtask
endmodule
`default_nettype wire

// ---- verification/split_packet_cell_handshake_port_tb_top.sv ----
// self-checking bench for the cell port target
`default_nettype none
module split_packet_cell_handshake_port_tb_top import cell_port_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic slowRsp = 1'b0;
    logic cmdVal, cmdAck, cmdContig, cmdConst, cmdEop, rspVal, rspAck, rspEop;
    logic cmdWrap, cmdCfixed;
    logic [7:0] cmdClen;
    logic [31:0] cmdAddress, cmdWdata, rspData, rdata;
    logic [8:0] cmdPlen;
    logic [3:0] cmdBe;
    logic [1:0] cmdOp, rspError, bresp, rresp;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [34:0] rq[$];
    int errors = 0;
    int samples_checked = 0;
    cell_port_target #(.ADDR_W(32), .MEM_DEPTH(16)) dut_u (.clock, .resetn, .cmdVal, .cmdAck, .cmdAddress,
        .cmdBe, .cmdOp, .cmdContig, .cmdWrap, .cmdConst, .cmdPlen, .cmdEop, .cmdWdata,
        .cmdClen, .cmdCfixed, .rspVal, .rspAck, .rspData, .rspEop, .rspError,
        .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp);
    cell_port_initiator init_u (.clock, .slowRsp, .cmdVal, .cmdAck, .cmdAddress, .cmdOp, .cmdContig,
        .cmdConst, .cmdPlen, .cmdEop, .cmdWdata, .cmdBe, .cmdWrap, .cmdClen, .cmdCfixed, .rspAck);
    initial begin
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rspVal === 1'b1 && rspAck === 1'b1) begin
            rq.push_back({rspError, rspEop, rspData});
        end
    end
    task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        fork
            begin
                do @(posedge clock); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge clock); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        do @(posedge clock); while (bvalid !== 1'b1);
        chk(35'(bresp), 35'(exp));
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        chk(35'({rresp, rresp == AXI_OKAY ? rdata : d}), 35'({exp, d}));
        rready <= 1'b0;
    endtask
    task automatic rsp(input logic [31:0] d, input logic e, input logic [1:0] er);
        wait (rq.size() != 0);
        chk(rq.pop_front(), {er, e, d});
    endtask
    task automatic t_reset();
        chk(35'(cmdAck), 35'h1);
        rd(CTRL_OFFSET, 32'h1, AXI_OKAY);
        wr(STATUS_OFFSET, 32'hffffffff, AXI_OKAY);
        rd(STATUS_OFFSET, 32'h0, AXI_OKAY);
        wr(8'h18, 32'h0, AXI_SLVERR);
        rd(8'h18, 32'h0, AXI_SLVERR);
    endtask
    task automatic t_stream();
        init_u.pkt(4, 32'h0, 1, OP_WRITE, 1'b1, 1'b0);
        init_u.pkt(4, 32'h0, 1, OP_READ, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rsp(32'h0, i == 3, ERR_NONE);
        end
        for (int i = 0; i < 4; i++) begin
            rsp(32'h5a000000 | 32'(4 * i), i == 3, ERR_NONE);
        end
        rd(CELLS_OFFSET, 32'h8, AXI_OKAY);
        rd(PACKETS_OFFSET, 32'h2, AXI_OKAY);
        rd(TIMING_OFFSET, 32'h0, AXI_OKAY);
    endtask
    task automatic t_slow();
        slowRsp <= 1'b1;
        init_u.pkt(3, 32'h4, 1, OP_READ, 1'b1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            rsp(32'h5a000004 + 32'(4 * i), i == 2, ERR_NONE);
        end
        slowRsp <= 1'b0;
    endtask
    task automatic t_err();
        for (int m = 1; m < 4; m++) begin
            wr(CTRL_OFFSET, 32'(m * 2 + 1), AXI_OKAY);
            init_u.pkt(2, 32'h0, 1, OP_READ, 1'b1, 1'b0);
            rsp(32'h0, 1'b0, 2'(m));
            rsp(32'h0, 1'b1, 2'(m));
        end
        wr(CTRL_OFFSET, 32'h1, AXI_OKAY);
        init_u.pkt(1, 32'h80000000, 1, OP_READ, 1'b1, 1'b0);
        rsp(32'h0, 1'b1, ERR_GENERAL);
        init_u.pkt(1, 32'h0, 1, OP_NOP, 1'b1, 1'b0);
        rsp(32'h0, 1'b1, ERR_NONE);
    endtask
    task automatic t_lock();
        logic [31:0] base[3] = '{32'h0, 32'h10, 32'h8};
        int st[3] = '{1, 2, 0};
        logic [31:0] lk[3] = '{32'h3, 32'h10, 32'h4};
        for (int i = 0; i < 3; i++) begin
            init_u.pkt(2, base[i], st[i], OP_LOCKREAD, i == 0, i == 2);
            wait (rq.size() == 2);
            rq.delete();
            rd(LOCKS_OFFSET, lk[i], AXI_OKAY);
            init_u.pkt(2, base[i], st[i], OP_WRITE, i == 0, i == 2);
            wait (rq.size() == 2);
            rq.delete();
            rd(LOCKS_OFFSET, 32'h0, AXI_OKAY);
        end
    endtask
    task automatic t_ackoff();
        wr(CTRL_OFFSET, 32'h0, AXI_OKAY);
        fork
            init_u.pkt(1, 32'h4, 1, OP_READ, 1'b1, 1'b0);
            begin
                repeat (4) @(posedge clock);
                chk(35'({cmdVal, cmdAck}), 35'h2);
                chk(35'(rq.size()), 35'h0);
                wr(CTRL_OFFSET, 32'h1, AXI_OKAY);
            end
        join
        rsp(32'h5a000004, 1'b1, ERR_NONE);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_stream();
        t_slow();
        t_err();
        t_lock();
        t_ackoff();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
